// [dv/watchdog_and_reset_sources_test.sv]
// Self-checking bench for the watchdog and reset-source block.
// Assumes wdr_top, its checker bind and the oscillator model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module watchdog_and_reset_sources_test;
    logic clk, nrst, supply_low, supply_above_por, reset_pin_n, timeout_response_select;
    logic watchdog_always_run, drop_detect_keep_on, stop_mode, wdt_cmd, wdt_off_cmd;
    logic cause_clear, sys_reset_n, wdt_irq, wdt_running, wdt_osc;
    logic [7:0] reload_upper_byte, reload_high_byte, reload_low_byte, reset_cause_register;
    logic [23:0] wdt_count;
    int n_mismatch = 0;
    int comparisons = 0;
    int n;

    wdr_top uut
    (
        .clk, .nrst, .supply_low, .supply_above_por, .reset_pin_n, .wdt_osc,
        .timeout_response_select, .watchdog_always_run, .drop_detect_keep_on, .stop_mode,
        .wdt_cmd, .wdt_off_cmd, .cause_clear, .reload_upper_byte, .reload_high_byte,
        .reload_low_byte, .sys_reset_n, .wdt_irq, .reset_cause_register, .wdt_running,
        .wdt_count
    );
    wdr_osc_model #(.HALF(20)) osc (.clk, .wdt_osc);

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Inputs always move 1 ns after the edge so the design samples settled values.
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    task automatic wait_rst();
        for (int i = 0; i < 200 && sys_reset_n !== 1'b1; i++)
            cyc(1);
        check(sys_reset_n, 1'b1);
    endtask : wait_rst
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    // ************************************************************
    // Clock, watchdog and tests
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    // The tests need under 3000 cycles; the limit leaves a wide margin.
    initial
    begin
        #50000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        {nrst, supply_low, stop_mode, wdt_cmd, wdt_off_cmd, cause_clear} = 6'h00;
        {supply_above_por, reset_pin_n, timeout_response_select} = 3'h7;
        {watchdog_always_run, drop_detect_keep_on} = 2'h2;
        {reload_upper_byte, reload_high_byte, reload_low_byte} = 24'h010203;
        cyc(4);
        check(reset_cause_register, 8'h80);
        check(wdt_count, 24'hFFFFFF);
        nrst = 1'b1;
        wait_rst();
        check(wdt_running, 1'b0);
        // Enable, refresh after some counts, then switch off.
        pulse(wdt_cmd);
        check(wdt_count, 24'h010203);
        cyc(100);
        check(wdt_count < 24'h010203, 1'b1);
        pulse(wdt_cmd);
        check(wdt_count, 24'h010203);
        pulse(wdt_off_cmd);
        check(wdt_running, 1'b0);
        $display("test enable done");
        // Interrupt response, with a refresh that comes too late.
        timeout_response_select = 1'b0;
        {reload_upper_byte, reload_high_byte, reload_low_byte} = 24'h000004;
        pulse(wdt_cmd);
        for (n = 0; n < 400 && wdt_count !== 24'h2; n++)
            cyc(1);
        pulse(wdt_cmd);
        check(wdt_count <= 24'h2, 1'b1);
        for (n = n + 1; n < 400 && wdt_irq !== 1'b1; n++)
            cyc(1);
        check(wdt_irq, 1'b1);
        check(n > 110 && n < 175, 1'b1);
        check(wdt_count, 24'h0);
        check(sys_reset_n, 1'b1);
        cyc(100);
        check(wdt_irq | wdt_running, 1'b0);
        $display("test interrupt done");
        // Reset response after re-arming.
        timeout_response_select = 1'b1;
        pulse(wdt_cmd);
        for (n = 0; n < 400 && sys_reset_n !== 1'b0; n++)
            cyc(1);
        check(reset_cause_register, 8'h20);
        wait_rst();
        check(wdt_running, 1'b0);
        $display("test time-out reset done");
        // A two-cycle pin pulse is ignored, a four-cycle one resets.
        reset_pin_n = 1'b0;
        cyc(2);
        reset_pin_n = 1'b1;
        cyc(10);
        check(sys_reset_n, 1'b1);
        reset_pin_n = 1'b0;
        cyc(4);
        reset_pin_n = 1'b1;
        cyc(3);
        check(sys_reset_n, 1'b0);
        check(reset_cause_register, 8'h10);
        wait_rst();
        $display("test pin done");
        // Supply drop, ignored in STOP until the keep-on option is set.
        pulse(cause_clear);
        check(reset_cause_register, 8'h00);
        stop_mode = 1'b1;
        supply_low = 1'b1;
        cyc(10);
        check(sys_reset_n, 1'b1);
        drop_detect_keep_on = 1'b1;
        cyc(8);
        check(sys_reset_n, 1'b0);
        supply_above_por = 1'b0;
        stop_mode = 1'b0;
        cyc(20);
        supply_low = 1'b0;
        cyc(30);
        check(sys_reset_n, 1'b0);
        supply_above_por = 1'b1;
        wait_rst();
        check(reset_cause_register, 8'h80);
        $display("test supply drop done");
        // Forced-on option across a second power-on reset.
        {reload_upper_byte, reload_high_byte, reload_low_byte} = 24'h000100;
        nrst = 1'b0;
        watchdog_always_run = 1'b0;
        cyc(2);
        nrst = 1'b1;
        wait_rst();
        check(wdt_running, 1'b1);
        pulse(wdt_off_cmd);
        check(wdt_running, 1'b1);
        $display("test forced on done");
        complete_run();
    end
endmodule : watchdog_and_reset_sources_test

`default_nettype wire

// [dv/wdr_monitor.sv]
// Concurrent checks on the ports of the watchdog and reset-source block.
// Assumes it is bound to wdr_top and that option bits and reload bytes change rarely.
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Checker
// ************************************************************
module wdr_monitor
(
    // Clock and power-on reset.
    input wire logic clk,
    input wire logic nrst,
    // Inputs of the block.
    input wire logic supply_low,
    input wire logic supply_above_por,
    input wire logic reset_pin_n,
    input wire logic timeout_response_select,
    input wire logic watchdog_always_run,
    input wire logic drop_detect_keep_on,
    input wire logic stop_mode,
    input wire logic wdt_cmd,
    input wire logic wdt_off_cmd,
    input wire logic [7:0] reload_upper_byte,
    input wire logic [7:0] reload_high_byte,
    input wire logic [7:0] reload_low_byte,
    // Outputs of the block.
    input wire logic sys_reset_n,
    input wire logic wdt_irq,
    input wire logic [7:0] reset_cause_register,
    input wire logic wdt_running,
    input wire logic [23:0] wdt_count
);
    logic [23:0] reload;
    logic live;
    // Live means the core may talk to a running watchdog.
    assign reload = {reload_upper_byte, reload_high_byte, reload_low_byte};
    assign live = sys_reset_n && wdt_running;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_irq_pulse; wdt_irq |=> !wdt_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
    property p_irq_mode; wdt_irq |-> !timeout_response_select && wdt_count == 24'h0; endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq in wrong mode or count");
    property p_wdt_reset;
        $fell(wdt_running) && wdt_count == 24'h0 && timeout_response_select && sys_reset_n
            |-> ##[1:3] (!sys_reset_n && reset_cause_register[5]);
    endproperty
    a_wdt_reset: assert property (p_wdt_reset) else $error("time-out gave no reset");
    property p_load; $rose(wdt_running) |-> wdt_count == reload; endproperty
    a_load: assert property (p_load) else $error("start without reload value");
    property p_refresh; live && wdt_cmd && wdt_count > 24'h2 |=> wdt_count == reload; endproperty
    a_refresh: assert property (p_refresh) else $error("refresh did not reload");
    property p_late; live && wdt_cmd && wdt_count <= 24'h2 |=> wdt_count != reload; endproperty
    a_late: assert property (p_late) else $error("late refresh accepted");
    property p_step;
        live && !wdt_cmd |=> !sys_reset_n || wdt_count == $past(wdt_count)
            || wdt_count == $past(wdt_count) - 24'h1;
    endproperty
    a_step: assert property (p_step) else $error("count jumped");
    property p_forced;
        live && !watchdog_always_run && wdt_off_cmd && wdt_count > 24'h1
            |=> wdt_running || !sys_reset_n;
    endproperty
    a_forced: assert property (p_forced) else $error("forced watchdog switched off");
    property p_pin;
        !reset_pin_n [*4] |-> ##[0:3] (!sys_reset_n && reset_cause_register[4]);
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset not taken");
    property p_drop;
        (supply_low && (!stop_mode || drop_detect_keep_on)) [*3] |-> ##[1:4] !sys_reset_n;
    endproperty
    a_drop: assert property (p_drop) else $error("supply drop not taken");
    property p_por_hold; !supply_above_por [*8] |-> !sys_reset_n; endproperty
    a_por_hold: assert property (p_por_hold) else $error("reset left below threshold");

    c_irq: cover property (wdt_irq);
    c_wdt: cover property ($rose(reset_cause_register[5]));
    c_pin: cover property ($rose(reset_cause_register[4]));
endmodule : wdr_monitor

bind wdr_top wdr_monitor u_mon
(
    .clk, .nrst, .supply_low, .supply_above_por, .reset_pin_n, .timeout_response_select,
    .watchdog_always_run, .drop_detect_keep_on, .stop_mode, .wdt_cmd, .wdt_off_cmd,
    .reload_upper_byte, .reload_high_byte, .reload_low_byte, .sys_reset_n, .wdt_irq,
    .reset_cause_register, .wdt_running, .wdt_count
);

`default_nettype wire

// [dv/wdr_osc_model.sv]
// Model of the dedicated RC oscillator that steps the watchdog.
// Assumes the bench picks a half period in system clock cycles.
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Oscillator
// ************************************************************
module wdr_osc_model
#(
    parameter int HALF = 20
)
(
    // System clock used only to time the model.
    input wire logic clk,
    // Oscillator output, one count per rising edge.
    output var logic wdt_osc
);
    int cnt = 0;
    // Runs free from power-up; far faster than 10 kHz so that time-outs fit a short run.
    always @(posedge clk)
    begin
        cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
    end
    // Low for the first half period, so the first rise follows a clean low level.
    assign wdt_osc = (cnt >= HALF);
endmodule : wdr_osc_model

`default_nettype wire

// [hw/wdr_pkg.sv]
// Constants shared by the watchdog and reset-source block.
// Assumes one 200 MHz system clock and a free-running 10 kHz RC oscillator input.
package wdr_pkg;

    // ************************************************************
    // Clocks and time
    // ************************************************************
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned WDT_OSC_HZ = 10_000;
    // One count per oscillator period, so the time-out in ms is reload / 10.
    localparam int unsigned WDT_COUNTS_PER_MS = WDT_OSC_HZ / 1000;

    // ************************************************************
    // Watchdog counter
    // ************************************************************
    localparam int unsigned WDT_W = 24;
    localparam int unsigned BYTE_W = 8;
    localparam logic [23:0] WDT_NO_REFRESH = 24'h000002;
    localparam logic [23:0] WDT_MIN_RELOAD = 24'h000004;
    localparam logic [23:0] WDT_COUNT_RESET = 24'hFFFFFF;

    // ************************************************************
    // External reset pin
    // ************************************************************
    localparam int unsigned EXT_RST_MIN_CYC = 4;
    // Sampling is asynchronous, so the request is taken one cycle early.
    localparam logic [2:0] EXT_RST_ACCEPT = 3'(EXT_RST_MIN_CYC - 1);

    // ************************************************************
    // System reset sequence
    // ************************************************************
    localparam logic [4:0] SYS_RST_CYCLES = 5'h10;

    // ************************************************************
    // Reset cause register layout
    // ************************************************************
    localparam int unsigned CAUSE_POR_BIT = 7;
    localparam int unsigned CAUSE_WDT_BIT = 5;
    localparam int unsigned CAUSE_EXT_BIT = 4;
    localparam logic [7:0] CAUSE_RESET = 8'h80;

    // ************************************************************
    // Synchroniser
    // ************************************************************
    localparam int unsigned SYNC_W = 4;
    localparam int unsigned SYNC_SUPPLY_LOW = 0;
    localparam int unsigned SYNC_SUPPLY_OK = 1;
    localparam int unsigned SYNC_PIN = 2;
    localparam int unsigned SYNC_OSC = 3;

endpackage : wdr_pkg

// [hw/wdr_rst_seq.sv]
// System reset sequencer: stretches any reset request into a full sequence.
// Assumes the request is a level on the system clock that may last one cycle.
`timescale 1ns/1ps
`default_nettype none

module wdr_rst_seq
(
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Reset request and the sequenced system reset.
    input wire logic hold,
    output logic sys_reset_n
);

    typedef struct packed {
        logic [4:0] cnt;
        logic rst_n;
    } wdr_seq_t;

    wdr_seq_t s;
    wdr_seq_t next_s;

    // A request restarts the count, so a short pulse still gets the full length.
    always_comb
    begin
        next_s = s;
        if (hold)
        begin
            next_s.cnt = '0;
            next_s.rst_n = 1'b0;
        end
        else if (s.cnt != wdr_pkg::SYS_RST_CYCLES)
        begin
            next_s.cnt = s.cnt + 5'h01;
            next_s.rst_n = 1'b0;
        end
        else
        begin
            next_s.rst_n = 1'b1;
        end
    end

    // Power-up starts a sequence of its own.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign sys_reset_n = s.rst_n;

endmodule : wdr_rst_seq
`default_nettype wire

// [hw/wdr_sync.sv]
// Two-flop synchroniser for the asynchronous inputs of the reset block.
// Assumes inputs are slow levels; each bit is handled on its own.
`timescale 1ns/1ps
`default_nettype none

module wdr_sync
(
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Raw asynchronous levels and their synchronised copies.
    input wire logic [wdr_pkg::SYNC_W-1:0] async_in,
    output logic [wdr_pkg::SYNC_W-1:0] sync_out
);

    typedef struct packed {
        logic [wdr_pkg::SYNC_W-1:0] stage1;
        logic [wdr_pkg::SYNC_W-1:0] stage2;
    } wdr_sync_t;

    wdr_sync_t s;
    wdr_sync_t next_s;

    // Each bit takes two flops; only the second stage is visible.
    genvar i;
    generate
        for (i = 0; i < wdr_pkg::SYNC_W; i++)
        begin : g_bit
            always_comb
            begin
                next_s.stage1[i] = async_in[i];
                next_s.stage2[i] = s.stage1[i];
            end
        end
    endgenerate

    // Inputs reset low; the pin reset then reads as asserted, the supply as below the power-on level with no drop.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign sync_out = s.stage2;

endmodule : wdr_sync
`default_nettype wire

// [hw/wdr_top.sv]
// Watchdog timer and system reset sources: supply drop, external pin, watchdog.
// Assumes option bits are static, core commands are one-cycle pulses on clk,
// and supply levels, reset pin and RC oscillator arrive asynchronously.
// Assumes the reload bytes hold still around a load; they are read only
// when the counter loads, so a new value applies from the next load on.
`timescale 1ns/1ps
`default_nettype none

module wdr_top
(
    // Clock and power-on reset.
    input wire logic clk,
    input wire logic nrst,
    // Analog and pin inputs, asynchronous to clk.
    input wire logic supply_low,
    input wire logic supply_above_por,
    input wire logic reset_pin_n,
    input wire logic wdt_osc,
    // Nonvolatile option bits.
    input wire logic timeout_response_select,
    input wire logic watchdog_always_run,
    input wire logic drop_detect_keep_on,
    // Processor core state and commands.
    input wire logic stop_mode,
    input wire logic wdt_cmd,
    input wire logic wdt_off_cmd,
    input wire logic cause_clear,
    // Reload value registers.
    input wire logic [7:0] reload_upper_byte,
    input wire logic [7:0] reload_high_byte,
    input wire logic [7:0] reload_low_byte,
    // Reset and interrupt outputs.
    output logic sys_reset_n,
    output logic wdt_irq,
    // Status outputs.
    output logic [7:0] reset_cause_register,
    output logic wdt_running,
    output logic [23:0] wdt_count
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic drop_hold;
        logic [2:0] pin_cnt;
        logic osc_prev;
        logic wdt_on;
        logic wdt_fired;
        logic running;
        logic wdt_rst_pend;
        logic irq;
        logic [23:0] count;
        logic [7:0] cause;
    } wdr_state_t;

    wdr_state_t s;
    wdr_state_t next_s;

    logic [wdr_pkg::SYNC_W-1:0] raw_in;
    logic [wdr_pkg::SYNC_W-1:0] syn;
    logic seq_reset_n;
    logic drop_seen;
    logic supply_ok;
    logic pin_low;
    logic pin_req;
    logic osc_tick;
    logic forced_on;
    logic [23:0] reload;
    logic [23:0] dec_count;
    logic seq_hold;
    logic cmd_reloads;

    // ************************************************************
    // Input synchronisation
    // ************************************************************

    // Every asynchronous level passes two flops before anything reads it.
    assign raw_in[wdr_pkg::SYNC_SUPPLY_LOW] = supply_low;
    assign raw_in[wdr_pkg::SYNC_SUPPLY_OK] = supply_above_por;
    assign raw_in[wdr_pkg::SYNC_PIN] = reset_pin_n;
    assign raw_in[wdr_pkg::SYNC_OSC] = wdt_osc;

    wdr_sync u_sync
    (
        .clk(clk),
        .nrst(nrst),
        .async_in(raw_in),
        .sync_out(syn)
    );

    // ************************************************************
    // Decoded conditions
    // ************************************************************

    // In STOP the detector only looks at the supply when the keep-on bit says so.
    assign drop_seen = syn[wdr_pkg::SYNC_SUPPLY_LOW] & (~stop_mode | drop_detect_keep_on);
    assign supply_ok = syn[wdr_pkg::SYNC_SUPPLY_OK];
    assign pin_low = ~syn[wdr_pkg::SYNC_PIN];
    // The count already holds the previous low samples, so this is the third in a row.
    assign pin_req = pin_low && (s.pin_cnt >= wdr_pkg::EXT_RST_ACCEPT - 3'h1);
    // Rising edge of the synchronised RC oscillator; one step per oscillator period.
    assign osc_tick = syn[wdr_pkg::SYNC_OSC] & ~s.osc_prev;
    // The always-run option is active low: 0 forces the watchdog on.
    assign forced_on = ~watchdog_always_run;
    // Upper, high, low byte order forms the reload value.
    assign reload = {reload_upper_byte, reload_high_byte, reload_low_byte};
    assign dec_count = s.count - 24'h000001;

    // A refused late refresh reloads nothing, so it must not swallow the tick
    // either; otherwise a core issuing the command on every cycle at count two
    // could hold the time-out off forever.
    assign cmd_reloads = wdt_cmd
        && (!s.wdt_on || s.wdt_fired || (s.count > wdr_pkg::WDT_NO_REFRESH));

    // Any active source holds the sequencer; the watchdog request lasts one cycle.
    assign seq_hold = s.drop_hold | pin_req | s.wdt_rst_pend;

    // ************************************************************
    // System reset sequencer
    // ************************************************************
    wdr_rst_seq u_seq
    (
        .clk(clk),
        .nrst(nrst),
        .hold(seq_hold),
        .sys_reset_n(seq_reset_n)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************

    // Reset sources, cause flags and the watchdog counter in one pass.
    always_comb
    begin
        next_s = s;
        next_s.osc_prev = syn[wdr_pkg::SYNC_OSC];
        next_s.irq = 1'b0;
        next_s.wdt_rst_pend = 1'b0;

        // The drop hold releases only above the higher power-on level, so the
        // hysteresis band can never end the hold early.
        if (drop_seen)
        begin
            next_s.drop_hold = 1'b1;
        end
        else if (s.drop_hold && supply_ok)
        begin
            next_s.drop_hold = 1'b0;
        end

        // Count consecutive low samples of the pin, saturating.
        // Saturation stops a long hold from wrapping back below the accept count.
        if (!pin_low)
        begin
            next_s.pin_cnt = '0;
        end
        else if (s.pin_cnt != wdr_pkg::EXT_RST_ACCEPT)
        begin
            next_s.pin_cnt = s.pin_cnt + 3'h1;
        end

        // Software clear comes first so that a cause arriving in the same
        // cycle still lands in the register.
        if (cause_clear)
        begin
            next_s.cause = '0;
        end
        // Supply drop wins over the pin, the pin over the watchdog; the register then names a single cause.
        if (s.drop_hold)
        begin
            next_s.cause = '0;
            next_s.cause[wdr_pkg::CAUSE_POR_BIT] = 1'b1;
        end
        else if (pin_req)
        begin
            next_s.cause = '0;
            next_s.cause[wdr_pkg::CAUSE_EXT_BIT] = 1'b1;
        end
        else if (s.wdt_rst_pend)
        begin
            next_s.cause = '0;
            next_s.cause[wdr_pkg::CAUSE_WDT_BIT] = 1'b1;
        end

        // During a system reset sequence the watchdog is put back to its
        // start state; the option alone decides if it runs right away.
        if (!seq_reset_n)
        begin
            next_s.wdt_on = forced_on;
            next_s.wdt_fired = 1'b0;
            next_s.count = reload;
        end
        else
        begin
            if (wdt_cmd)
            begin
                if (!s.wdt_on || s.wdt_fired)
                begin
                    // Switch on, or re-arm after an interrupt time-out.
                    next_s.wdt_on = 1'b1;
                    next_s.wdt_fired = 1'b0;
                    next_s.count = reload;
                end
                else if (s.count > wdr_pkg::WDT_NO_REFRESH)
                begin
                    // Refresh is refused once the count is down to two.
                    next_s.count = reload;
                end
            end
            else if (wdt_off_cmd && !forced_on)
            begin
                // Off, running and fired are the states; off simply freezes the count.
                next_s.wdt_on = 1'b0;
            end

            // A reload in this cycle takes precedence over a tick, which
            // costs at most one oscillator period of time-out length.
            // A refused refresh reloads nothing, so its tick still counts.
            if (s.wdt_on && !s.wdt_fired && osc_tick && !cmd_reloads)
            begin
                next_s.count = dec_count;
                if (dec_count == '0)
                begin
                    // Terminal count: fire once and stay fired.
                    next_s.wdt_fired = 1'b1;
                    if (timeout_response_select)
                    begin
                        next_s.wdt_rst_pend = 1'b1;
                    end
                    else
                    begin
                        next_s.irq = 1'b1;
                    end
                end
            end
        end

        // Registered so that the status output comes straight from a flop.
        next_s.running = next_s.wdt_on & ~next_s.wdt_fired;
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Power-on reset: cause reads power-on, watchdog starts from the top.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s.drop_hold <= 1'b0;
            s.pin_cnt <= '0;
            s.osc_prev <= 1'b0;
            s.wdt_on <= 1'b0;
            s.wdt_fired <= 1'b0;
            s.running <= 1'b0;
            s.wdt_rst_pend <= 1'b0;
            s.irq <= 1'b0;
            s.count <= wdr_pkg::WDT_COUNT_RESET;
            s.cause <= wdr_pkg::CAUSE_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // All outputs come from flops of this block or of the sequencer.
    // The sequencer output is its own flop, so no gate sits on the reset path.
    assign sys_reset_n = seq_reset_n;
    assign wdt_irq = s.irq;
    assign reset_cause_register = s.cause;
    assign wdt_running = s.running;
    assign wdt_count = s.count;

endmodule : wdr_top
`default_nettype wire
